/* File: dv/down_timer_pair_props.sv */
`timescale 1ns/100ps
`default_nettype none
module down_timer_pair_props (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Pins and requests
  input wire logic        port_b_line_2,
  input wire logic        port_b_line_2_oe,
  input wire logic        port_b_line_5,
  input wire logic        port_b_line_5_oe,
  input wire logic        ch2_irq_request
);
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reset_idle_a: assert property (disable iff (1'b0) !aresetn |=>
    s_axi_awready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid
    && !port_b_line_5_oe && !ch2_irq_request) else $error("not idle");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("no write response");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("no read data");
  ready_low_a: assert property ($rose(s_axi_bvalid) |->
    !s_axi_awready && !s_axi_wready) else $error("ready during response");
  write_release_a: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write not released");
  read_release_a: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid && s_axi_arready) else $error("read not released");
  read_width_a: assert property (s_axi_rvalid |->
    s_axi_rdata[31:10] == 22'h0) else $error("read data too wide");
  wave_priority_a: assert property (port_b_line_5_oe |->
    port_b_line_2_oe && port_b_line_2 == port_b_line_5)
    else $error("wave lost shared pin");
endmodule // down_timer_pair_props

bind down_timer_pair down_timer_pair_props props (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .port_b_line_2,
  .port_b_line_2_oe, .port_b_line_5, .port_b_line_5_oe, .ch2_irq_request);
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        instruction_tick = 1'b0, internal_fast_oscillator = 1'b0;
  logic        external_count_pin = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire         s_axi_rvalid, port_b_line_2, port_b_line_2_oe, port_b_line_5;
  wire         port_b_line_5_oe, port_a_line_2, port_a_line_2_oe;
  wire         ch2_irq_request, ch3_irq_request;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  int          n_errors = 0, checked = 0;
  integer      seed = 32'hf10a72c6;
  logic [9:0]  r, c;
  logic        v;
  logic [33:0] bq[$], rq[$];

  down_timer_pair dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .instruction_tick, .internal_fast_oscillator,
    .external_count_pin, .port_b_line_2, .port_b_line_2_oe, .port_b_line_5,
    .port_b_line_5_oe, .port_a_line_2, .port_a_line_2_oe, .ch2_irq_request,
    .ch3_irq_request);

  always #2.5 aclk = ~aclk;

  // ----------------------------------------------------------------------
  // Bus master and checking
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [33:0] e, g);
    checked++;
    if (e !== g) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d,
                    input logic [1:0] rr);
    bq.push_back({32'h0, rr});
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_awaddr <= {25'h0, a};
    s_axi_wdata <= {24'h0, d};
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) ||
               (s_axi_wvalid && !s_axi_wready));
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [31:0] d,
                    input logic [1:0] rr = 2'b00);
    rq.push_back({rr, d});
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= {25'h0, a};
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // Count pulses one cycle wide; the tail lets the registered counter and pin outputs settle
  task automatic tk(input bit f, input int n);
    repeat (n) begin
      @(posedge aclk);
      if (f) internal_fast_oscillator <= 1'b1;
      else instruction_tick <= 1'b1;
      @(posedge aclk);
      internal_fast_oscillator <= 1'b0;
      instruction_tick <= 1'b0;
    end
    repeat (3) @(posedge aclk);
  endtask

  // Slow pin edges so the two-stage synchroniser sees every level
  task automatic ep(input int n);
    repeat (n) begin
      @(posedge aclk) external_count_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      external_count_pin <= 1'b0;
      repeat (4) @(posedge aclk);
    end
  endtask

  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) chk("bresp", bq.pop_front(), {32'h0, s_axi_bresp});
    if (s_axi_rvalid && s_axi_rready) chk("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
  end

  task automatic give_verdict;
    if (n_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #250000;
    n_errors++;
    give_verdict();
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(7'h08, 32'h3ff);
    rd(7'h28, 32'h3ff);
    rd(7'h44, 32'h0, 2'b10);
    wr(7'h44, 8'h01, 2'b10);
    r = 10'(({$random(seed)} % 384) + 64);
    wr(7'h0c, {2'b00, r[9:8], 4'h0}, 2'b00);
    wr(7'h08, r[7:0], 2'b00);
    rd(7'h08, {22'h0, r});
    wr(7'h04, 8'h08, 2'b00);
    wr(7'h00, 8'h03, 2'b00);
    tk(0, 20);
    tk(1, 5);
    c = r - 10'd20;
    rd(7'h08, {22'h0, c});
    // Whole multiples of the ratio make the prescaler phase irrelevant
    for (int k = 0; k < 8; k++) begin
      wr(7'h04, 8'(k), 2'b00);
      tk(0, 4 << k);
      c = c - 10'd2;
      rd(7'h08, {22'h0, c});
    end
    // 1020 prescaler ticks since reset leave 0xfc
    rd(7'h14, 32'hfc);
    wr(7'h04, 8'h08, 2'b00);
    wr(7'h00, 8'h0b, 2'b00);
    tk(1, 6);
    tk(0, 4);
    c = c - 10'd6;
    rd(7'h08, {22'h0, c});
    wr(7'h00, 8'h03, 2'b00);
    wr(7'h04, 8'h28, 2'b00);
    ep(3);
    c = c - 10'd3;
    rd(7'h08, {22'h0, c});
    wr(7'h04, 8'h38, 2'b00);
    ep(2);
    c = c - 10'd2;
    rd(7'h08, {22'h0, c});
    wr(7'h00, 8'h02, 2'b00);
    wr(7'h0c, 8'h00, 2'b00);
    wr(7'h08, 8'h03, 2'b00);
    wr(7'h04, 8'h08, 2'b00);
    wr(7'h00, 8'h03, 2'b00);
    wr(7'h40, 8'h01, 2'b00);
    wr(7'h1c, 8'h02, 2'b00);
    wr(7'h08, 8'h05, 2'b00);
    rd(7'h08, 32'h3);
    tk(0, 4);
    rd(7'h08, 32'h5);
    rd(7'h1c, 32'h3);
    chk("irq", 34'h1, {33'h0, ch2_irq_request});
    wr(7'h1c, 8'h03, 2'b00);
    rd(7'h1c, 32'h3);
    wr(7'h1c, 8'h02, 2'b00);
    rd(7'h1c, 32'h2);
    chk("irq", 34'h0, {33'h0, ch2_irq_request});
    wr(7'h00, 8'h01, 2'b00);
    tk(0, 6);
    rd(7'h08, 32'h3ff);
    wr(7'h00, 8'h04, 2'b00);
    wr(7'h08, 8'h02, 2'b00);
    wr(7'h00, 8'h05, 2'b00);
    tk(0, 6);
    rd(7'h08, 32'h0);
    wr(7'h00, 8'h02, 2'b00);
    wr(7'h08, 8'h07, 2'b00);
    wr(7'h10, 8'h03, 2'b00);
    wr(7'h18, 8'h80, 2'b00);
    wr(7'h00, 8'h83, 2'b00);
    tk(0, 0);
    chk("oe", 34'h1, {33'h0, port_b_line_5_oe});
    chk("wave", 34'h0, {33'h0, port_b_line_5});
    tk(0, 5);
    chk("wave", 34'h1, {33'h0, port_b_line_5});
    chk("wave pin", 34'h1, {33'h0, port_b_line_2});
    wr(7'h00, 8'hc3, 2'b00);
    tk(0, 0);
    chk("wave", 34'h0, {33'h0, port_b_line_5});
    chk("wave pin", 34'h0, {33'h0, port_b_line_2});
    wr(7'h10, 8'h00, 2'b00);
    tk(0, 0);
    chk("wave", 34'h0, {33'h0, port_b_line_5});
    tk(0, 9);
    chk("wave", 34'h1, {33'h0, port_b_line_5});
    // Third channel: stretched trailing edge and its own request
    wr(7'h28, 8'h02, 2'b00);
    wr(7'h30, 8'h02, 2'b00);
    wr(7'h3c, 8'h02, 2'b00);
    wr(7'h24, 8'h48, 2'b00);
    wr(7'h20, 8'h89, 2'b00);
    tk(1, 2);
    chk("wave3", 34'h1, {33'h0, port_a_line_2});
    @(posedge aclk) internal_fast_oscillator <= 1'b1;
    @(posedge aclk) internal_fast_oscillator <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("stretch", 34'h1, {33'h0, port_a_line_2});
    @(posedge aclk);
    chk("stretch", 34'h0, {33'h0, port_a_line_2});
    chk("irq3", 34'h1, {33'h0, ch3_irq_request});
    wr(7'h24, 8'h08, 2'b00);
    wr(7'h20, 8'h01, 2'b00);
    wr(7'h38, 8'h80, 2'b00);
    tk(0, 0);
    chk("tone oe", 34'h1, {33'h0, port_a_line_2_oe});
    v = port_a_line_2;
    tk(0, 1);
    chk("tone", {33'h0, ~v}, {33'h0, port_a_line_2});
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire

/* File: rtl/down_timer_pair.v */
// Overview of operation
// - Each channel has a 10-bit down counter fed by a prescaler.
// - Upper reload bits then low byte; running continuous channel loads at underflow.
// - Stopped channel loads counter immediately on low reload write.
// - Count location reads the live counter value.
// - Fast oscillator select wins; else source bit picks pin or instr.
// - Edge select 1 counts falling pin edges, 0 rising edges.
// - Prescaler active when enable_n is 0; divides 1:2 to 1:256.
// - Prescaler counter value is readable per channel.
// - One-shot counts down once to zero, underflows, then stops.
// - Continuous with reload set restores stored initial value.
// - Continuous with reload clear restarts from 0x3FF unless a new reload is pending.
// - Underflow sets flag; irq when channel and global enables set.
// - Flag stays set until firmware writes 0 to it.
// - Wave enable routes PWM to its pin and forces output direction.
// - Polarity bit 1 makes PWM active low, 0 active high.
// - Duty 0 never active; 0x3FF active 1023 input clocks.
// - Upper duty bits then low byte; active duty updates at underflow.
// - Third channel on fast oscillator: half-step bit stretches pulse.
// - Tone enable drives buzzer on its pin unless wave enabled, forcing output direction.
// - Tone source bit 3 picks prescaler or timer; low bits divide.
`timescale 1ns/100ps
`default_nettype none
`include "down_timer_map.vh"

module down_timer_pair (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address and data
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // AXI4-Lite read
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  input  wire [31:0] s_axi_araddr,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  // Count sources, ticks one aclk cycle wide
  input  wire        instruction_tick,
  input  wire        internal_fast_oscillator,
  input  wire        external_count_pin,
  // Pins
  output reg         port_b_line_2,
  output reg         port_b_line_2_oe,
  output reg         port_b_line_5,
  output reg         port_b_line_5_oe,
  output reg         port_a_line_2,
  output reg         port_a_line_2_oe,
  // Interrupt requests
  output reg         ch2_irq_request,
  output reg         ch3_irq_request
);

  // --------------------------------------------------------------------
  // External pin synchroniser and edge detect
  // --------------------------------------------------------------------
  reg ext_meta;
  reg ext_sync;
  reg ext_last;
  // Edge register resets to the idle low of the pin: no false edge
  wire ext_rise = ext_sync & ~ext_last;
  wire ext_fall = ~ext_sync & ext_last;

  always @(posedge aclk) begin
    if (!aresetn) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_last <= 1'b0;
    end else begin
      ext_meta <= external_count_pin;
      ext_sync <= ext_meta;
      ext_last <= ext_sync;
    end
  end

  // --------------------------------------------------------------------
  // AXI4-Lite slave
  // --------------------------------------------------------------------
  // One write and one read in flight; slots reopen after the answer,
  // trading throughput for a slave with no queue
  reg [`ADDR_WIDTH-1:0] aw_addr;
  reg [31:0]            w_data;
  reg                   w_byte0;
  reg                   global_irq_enable;
  wire                  wr_fire = ~s_axi_awready & ~s_axi_wready &
                                  ~s_axi_bvalid;
  wire                  wr_ok   = ~aw_addr[6] ||
                                  aw_addr == `GLOBAL_OFFSET;
  // A write without lane 0 to a mapped address is answered OKAY and leaves registers alone
  wire                  wr_en   = wr_fire & wr_ok & w_byte0;
  wire [`ADDR_WIDTH-1:0] ar_addr = s_axi_araddr[`ADDR_WIDTH-1:0];
  wire [31:0]           ch_rdata [0:1];
  wire [1:0]            ch_irq;
  wire [1:0]            ch_wave_en;
  wire [1:0]            ch_wave_lvl;
  wire [1:0]            ch_tone_en;
  wire [1:0]            ch_tone_lvl;
  wire                  ar_global = ar_addr == `GLOBAL_OFFSET;
  wire                  ar_ok   = ~ar_addr[6] || ar_global;
  reg  [31:0]           next_rdata;

  always @* begin
    if (ar_global)
      next_rdata = {31'h0, global_irq_enable};
    else if (ar_ok)
      next_rdata = ch_rdata[ar_addr[5]];
    else
      next_rdata = 32'h0;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `RESP_OKAY;
      aw_addr       <= {`ADDR_WIDTH{1'b0}};
      w_data        <= 32'h0;
      w_byte0       <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr[`ADDR_WIDTH-1:0];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_byte0      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      // Address and data slots reopen only after the response is taken
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= next_rdata;
        s_axi_rresp   <= ar_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn)
      global_irq_enable <= 1'b0;
    else if (wr_en && aw_addr == `GLOBAL_OFFSET)
      global_irq_enable <= w_data[`BIT_GLOBAL_IRQ];
  end

  // --------------------------------------------------------------------
  // Timer channels: index 0 is channel 2, index 1 is channel 3
  // --------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chan
      reg  [7:0] ctrl_mode;
      reg  [7:0] ctrl_clock;
      reg  [7:0] tone_cfg;
      reg  [1:0] reload_hi_pend;
      reg  [1:0] duty_hi_pend;
      reg  [9:0] reload_buf;
      reg  [9:0] duty_buf;
      reg  [9:0] duty_act;
      reg  [9:0] count;
      reg        reload_pend;
      reg        done;
      reg        flag;
      reg        irq_en;
      reg  [7:0] presc;
      reg  [6:0] tone_cnt;
      reg        tone_lvl;
      reg        active_d;

      wire       sel     = wr_en && ~aw_addr[6] && (aw_addr[5] == (g == 1));
      wire [2:0] reg_idx = aw_addr[4:2];
      wire       wr_low  = sel && reg_idx == `OFS_COUNT;
      wire       run_bit = ctrl_mode[`BIT_RUN_ENABLE];
      wire       running = run_bit & ~done;
      wire       src_tick = ctrl_mode[`BIT_FAST_OSC] ?
                            internal_fast_oscillator :
                            ctrl_clock[`BIT_CLK_SRC] ?
                            (ctrl_clock[`BIT_EDGE_SEL] ?
                             ext_fall : ext_rise) : instruction_tick;
      wire [7:0] pmask   = ~(8'hfe << ctrl_clock[`FLD_RATIO_HI:`FLD_RATIO_LO]);
      // Prescaler pulses when the selected low bits are all ones
      wire       ptick   = ctrl_clock[`BIT_PRESC_EN_N] ? src_tick :
                           src_tick && ((presc | ~pmask) == 8'hff);
      wire       underflow = running && ptick && count == 10'h0;
      wire [9:0] new_reload = {reload_hi_pend, w_data[7:0]};
      wire       active  = run_bit && count < duty_act;
      // Stretch is one aclk, the finest step this clock domain has
      wire       stretch = (g == 1) && ctrl_clock[`BIT_HALF_STEP] &&
                           ctrl_mode[`BIT_FAST_OSC];
      wire       tsrc    = tone_cfg[`BIT_TONE_SRC] ? underflow : ptick;
      wire [6:0] tmask   = ~(7'h7f << tone_cfg[2:0]);
      reg  [31:0] rword;

      // ----------------------------------------------------------------
      // Readback and pin levels
      // ----------------------------------------------------------------
      always @* begin
        case (ar_addr[4:2])
          `OFS_CTRL_MODE:  rword = {24'h0, ctrl_mode};
          `OFS_CTRL_CLOCK: rword = {24'h0, ctrl_clock};
          `OFS_COUNT:      rword = {22'h0, count};
          `OFS_UPPER:      rword = {26'h0, reload_hi_pend, 2'b00,
                                    duty_hi_pend};
          `OFS_DUTY_LOW:   rword = {24'h0, duty_buf[7:0]};
          `OFS_PRESCALER:  rword = {24'h0, presc};
          `OFS_TONE:       rword = {24'h0, tone_cfg};
          `OFS_IRQ:        rword = {30'h0, irq_en, flag};
          default:         rword = 32'h0;
        endcase
      end
      assign ch_rdata[g]    = rword;
      assign ch_irq[g]      = flag & irq_en & global_irq_enable;
      assign ch_wave_en[g]  = ctrl_mode[`BIT_WAVE_OUT_EN];
      assign ch_wave_lvl[g] = (active | (stretch & active_d)) ^
                              ctrl_mode[`BIT_WAVE_ACT_LOW];
      assign ch_tone_en[g]  = tone_cfg[`BIT_TONE_EN];
      assign ch_tone_lvl[g] = tone_lvl;

      // ----------------------------------------------------------------
      // Register file
      // ----------------------------------------------------------------
      always @(posedge aclk) begin
        if (!aresetn) begin
          ctrl_mode      <= `RST_BYTE;
          ctrl_clock     <= `RST_BYTE;
          tone_cfg       <= `RST_BYTE;
          reload_hi_pend <= 2'b00;
          duty_hi_pend   <= 2'b00;
          reload_buf     <= `RST_COUNT;
          duty_buf       <= 10'h0;
          irq_en         <= 1'b0;
        end else if (sel) begin
          case (reg_idx)
            `OFS_CTRL_MODE:  ctrl_mode <= w_data[7:0];
            `OFS_CTRL_CLOCK: ctrl_clock <= (g == 1) ? w_data[7:0] :
                                           {1'b0, 1'b0, w_data[5:0]};
            `OFS_COUNT:      reload_buf <= new_reload;
            `OFS_UPPER: begin
              reload_hi_pend <= w_data[`FLD_RELOAD_HI:`FLD_RELOAD_LO];
              duty_hi_pend   <= w_data[`FLD_DUTYH_HI:`FLD_DUTYH_LO];
            end
            `OFS_DUTY_LOW:   duty_buf <= {duty_hi_pend, w_data[7:0]};
            `OFS_TONE:       tone_cfg <= {w_data[7], 3'b000, w_data[3:0]};
            `OFS_IRQ:        irq_en <= w_data[`BIT_IRQ_EN];
            default:         irq_en <= irq_en;
          endcase
        end
      end

      // ----------------------------------------------------------------
      // Prescaler, counter and flag
      // ----------------------------------------------------------------
      always @(posedge aclk) begin
        if (!aresetn) begin
          count       <= `RST_COUNT;
          reload_pend <= 1'b0;
          done        <= 1'b0;
          duty_act    <= 10'h0;
          presc       <= 8'h00;
          flag        <= 1'b0;
          active_d    <= 1'b0;
        end else begin
          active_d <= active;
          if (src_tick && !ctrl_clock[`BIT_PRESC_EN_N])
            presc <= presc + 8'h01;
          // Set wins over a firmware clear in the same cycle
          flag <= underflow |
                  (flag & ~(sel && reg_idx == `OFS_IRQ &&
                            !w_data[`BIT_FLAG]));
          if (underflow || !run_bit)
            duty_act <= duty_buf;
          if (sel && reg_idx == `OFS_CTRL_MODE &&
              w_data[`BIT_RUN_ENABLE] && !run_bit)
            done <= 1'b0;
          if (wr_low && !run_bit) begin
            count       <= new_reload;
            reload_pend <= 1'b0;
            done        <= 1'b0;
          end else if (running && ptick) begin
            if (count != 10'h0) begin
              count <= count - 10'h001;
              if (wr_low)
                reload_pend <= 1'b1;
            end else if (ctrl_mode[`BIT_ONE_SHOT]) begin
              done        <= 1'b1;
              // A reload written in this very cycle waits for the next one
              reload_pend <= wr_low;
            end else begin
              count <= (reload_pend || ctrl_mode[`BIT_RELOAD_SEL]) ?
                       reload_buf : `ALL_ONES_COUNT;
              reload_pend <= wr_low;
            end
          end else if (wr_low) begin
            reload_pend <= 1'b1;
          end
        end
      end

      // ----------------------------------------------------------------
      // Tone divider
      // ----------------------------------------------------------------
      always @(posedge aclk) begin
        if (!aresetn) begin
          tone_cnt <= 7'h00;
          tone_lvl <= 1'b0;
        end else if (tsrc) begin
          tone_cnt <= tone_cnt + 7'h01;
          if ((tone_cnt | ~tmask) == 7'h7f)
            tone_lvl <= ~tone_lvl;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Pin routing, wave before tone
  // --------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      port_b_line_2    <= 1'b0;
      port_b_line_2_oe <= 1'b0;
      port_b_line_5    <= 1'b0;
      port_b_line_5_oe <= 1'b0;
      port_a_line_2    <= 1'b0;
      port_a_line_2_oe <= 1'b0;
      ch2_irq_request  <= 1'b0;
      ch3_irq_request  <= 1'b0;
    end else begin
      port_b_line_2    <= ch_wave_en[0] ? ch_wave_lvl[0] :
                          ch_tone_lvl[0];
      port_b_line_2_oe <= ch_wave_en[0] | ch_tone_en[0];
      port_b_line_5    <= ch_wave_lvl[0];
      port_b_line_5_oe <= ch_wave_en[0];
      port_a_line_2    <= ch_wave_en[1] ? ch_wave_lvl[1] :
                          ch_tone_lvl[1];
      port_a_line_2_oe <= ch_wave_en[1] | ch_tone_en[1];
      ch2_irq_request  <= ch_irq[0];
      ch3_irq_request  <= ch_irq[1];
    end
  end

endmodule // down_timer_pair
`default_nettype wire

/* File: shared/down_timer_map.vh */
`ifndef DOWN_TIMER_MAP_VH
`define DOWN_TIMER_MAP_VH

// ----------------------------------------------------------------------
// Register map (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------------
`define ADDR_WIDTH        7
`define CH_BASE_2         7'h00
`define CH_BASE_3         7'h20
`define GLOBAL_OFFSET     7'h40
`define OFS_CTRL_MODE     3'h0
`define OFS_CTRL_CLOCK    3'h1
`define OFS_COUNT         3'h2
`define OFS_UPPER         3'h3
`define OFS_DUTY_LOW      3'h4
`define OFS_PRESCALER     3'h5
`define OFS_TONE          3'h6
`define OFS_IRQ           3'h7

// ----------------------------------------------------------------------
// Mode control fields
// ----------------------------------------------------------------------
`define BIT_WAVE_OUT_EN   7
`define BIT_WAVE_ACT_LOW  6
`define BIT_FAST_OSC      3
`define BIT_ONE_SHOT      2
`define BIT_RELOAD_SEL    1
`define BIT_RUN_ENABLE    0

// ----------------------------------------------------------------------
// Clock control fields
// ----------------------------------------------------------------------
`define BIT_HALF_STEP     6
`define BIT_CLK_SRC       5
`define BIT_EDGE_SEL      4
`define BIT_PRESC_EN_N    3
`define FLD_RATIO_HI      2
`define FLD_RATIO_LO      0

// ----------------------------------------------------------------------
// Upper bits, tone, irq fields
// ----------------------------------------------------------------------
`define FLD_RELOAD_HI     5
`define FLD_RELOAD_LO     4
`define FLD_DUTYH_HI      1
`define FLD_DUTYH_LO      0
`define BIT_TONE_EN       7
`define BIT_TONE_SRC      3
`define BIT_FLAG          0
`define BIT_IRQ_EN        1
`define BIT_GLOBAL_IRQ    0

// ----------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------
`define RST_BYTE          8'h00
`define RST_COUNT         10'h3ff
`define ALL_ONES_COUNT    10'h3ff
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif
